// ==== design/bstr_regs.sv ====
module bstr_regs
(
  input  wire logic                              MCLK,
  input  wire logic                              RESET_N,
  input  wire logic                              TEST_SHIFT_CLOCK,
  input  wire logic                              TEST_SERIAL_IN,
  input  wire logic [bstr_pkg::BSTR_IR_LEN-1:0]  INSTRUCTION,
  input  wire logic                              TAP_RESET_STATE,
  input  wire logic                              TAP_CAPTURE_DR,
  input  wire logic                              TAP_SHIFT_DR,
  input  wire logic                              TAP_UPDATE_DR,
  input  wire logic [bstr_pkg::BSTR_BSR_LEN-1:0] BOUNDARY_PINS,
  output logic                                   TEST_SERIAL_OUT,
  output logic                                   TEST_SERIAL_OUT_EN,
  output logic [bstr_pkg::BSTR_BSR_LEN-1:0]      BOUNDARY_PARALLEL,
  output logic [bstr_pkg::BSTR_ID_LEN-1:0]       ID_PARALLEL
);

  import bstr_pkg::*;

  // *****************************************************
  // test clock and input synchronisers
  // *****************************************************
  logic [2:0]              tck_r;
  logic [2:0]              tck_nxt;
  logic [1:0]              tdi_r;
  logic [1:0]              tdi_nxt;
  logic [BSTR_BSR_LEN-1:0] pins1_r;
  logic [BSTR_BSR_LEN-1:0] pins2_r;
  logic [BSTR_BSR_LEN-1:0] pins1_nxt;
  logic [BSTR_BSR_LEN-1:0] pins2_nxt;
  logic                    tck_rise;
  logic                    tck_fall;

  always_comb
  begin
    tck_nxt = {tck_r[1:0], TEST_SHIFT_CLOCK};
    tdi_nxt = {tdi_r[0], TEST_SERIAL_IN};
    pins1_nxt = BOUNDARY_PINS;
    pins2_nxt = pins1_r;
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      tck_r   <= 3'h0;
      tdi_r   <= 2'h0;
      pins1_r <= BSTR_BSR_RST;
      pins2_r <= BSTR_BSR_RST;
    end
    else
    begin
      tck_r   <= tck_nxt;
      tdi_r   <= tdi_nxt;
      pins1_r <= pins1_nxt;
      pins2_r <= pins2_nxt;
    end
  end

  // edges seen only from the second and third stages
  assign tck_rise = tck_r[1] & ~tck_r[2];
  assign tck_fall = ~tck_r[1] & tck_r[2];

  // *****************************************************
  // register selection
  // *****************************************************
  // test-logic-reset wins over whatever instruction is held
  function automatic bstr_sel_type pick_reg(
    input logic [BSTR_IR_LEN-1:0] ins,
    input logic                   tlr
  );
    bstr_sel_type pick;
    pick = BSTR_SEL_BYP;
    if (tlr)
      pick = BSTR_SEL_ID;
    else
    begin
      case (ins)
        BSTR_INS_IDCODE: pick = BSTR_SEL_ID;
        BSTR_INS_EXTEST,
        BSTR_INS_SAMPLE: pick = BSTR_SEL_BSR;
        // clamp, highz, bypass and the spare codes
        default:         pick = BSTR_SEL_BYP;
      endcase
    end
    return pick;
  endfunction

  bstr_sel_type sel;

  assign sel = pick_reg(INSTRUCTION, TAP_RESET_STATE);

  // *****************************************************
  // shift stages
  // *****************************************************
  logic                    byp_r;
  logic                    byp_nxt;
  logic [BSTR_BSR_LEN-1:0] bsr_r;
  logic [BSTR_BSR_LEN-1:0] bsr_nxt;
  logic [BSTR_ID_LEN-1:0]  id_r;
  logic [BSTR_ID_LEN-1:0]  id_nxt;

  always_comb
  begin
    byp_nxt = byp_r;
    bsr_nxt = bsr_r;
    id_nxt  = id_r;
    if (tck_rise && TAP_CAPTURE_DR)
    begin
      unique case (sel)
        BSTR_SEL_BYP: byp_nxt = BSTR_BYP_CAPTURE;
        BSTR_SEL_BSR: bsr_nxt = pins2_r;
        BSTR_SEL_ID:  id_nxt  = BSTR_ID_CODE;
      endcase
    end
    else if (tck_rise && TAP_SHIFT_DR)
    begin
      // only the selected register moves
      unique case (sel)
        BSTR_SEL_BYP: byp_nxt = tdi_r[1];
        BSTR_SEL_BSR: bsr_nxt = {tdi_r[1], bsr_r[BSTR_BSR_LEN-1:1]};
        BSTR_SEL_ID:  id_nxt  = {tdi_r[1], id_r[BSTR_ID_LEN-1:1]};
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      byp_r <= 1'b0;
      bsr_r <= BSTR_BSR_RST;
      id_r  <= BSTR_ID_CODE;
    end
    else
    begin
      byp_r <= byp_nxt;
      bsr_r <= bsr_nxt;
      id_r  <= id_nxt;
    end
  end

  // *****************************************************
  // parallel output latches and serial output
  // *****************************************************
  logic [BSTR_BSR_LEN-1:0] bsr_par_r;
  logic [BSTR_BSR_LEN-1:0] bsr_par_nxt;
  logic [BSTR_ID_LEN-1:0]  id_par_r;
  logic [BSTR_ID_LEN-1:0]  id_par_nxt;
  logic                    tdo_r;
  logic                    tdo_nxt;
  logic                    tdo_en_r;
  logic                    tdo_en_nxt;
  logic                    sel_lsb;

  // serial output source: the lsb of the selected register
  always_comb
  begin
    sel_lsb = 1'b0;
    unique case (sel)
      BSTR_SEL_BYP: sel_lsb = byp_r;
      BSTR_SEL_BSR: sel_lsb = bsr_r[0];
      BSTR_SEL_ID:  sel_lsb = id_r[0];
    endcase
  end

  always_comb
  begin
    bsr_par_nxt = bsr_par_r;
    id_par_nxt  = id_par_r;
    tdo_nxt     = tdo_r;
    tdo_en_nxt  = tdo_en_r;
    if (TAP_RESET_STATE)
      id_par_nxt = BSTR_ID_CODE;
    else if (tck_fall && TAP_UPDATE_DR)
    begin
      if (sel == BSTR_SEL_BSR)
        bsr_par_nxt = bsr_r;
      if (sel == BSTR_SEL_ID)
        id_par_nxt = id_r;
    end
    if (tck_fall)
    begin
      // serial output changes on the falling test clock
      tdo_en_nxt = TAP_SHIFT_DR;
      tdo_nxt    = sel_lsb;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bsr_par_r <= BSTR_BSR_RST;
      id_par_r  <= BSTR_ID_CODE;
      tdo_r     <= 1'b0;
      tdo_en_r  <= 1'b0;
    end
    else
    begin
      bsr_par_r <= bsr_par_nxt;
      id_par_r  <= id_par_nxt;
      tdo_r     <= tdo_nxt;
      tdo_en_r  <= tdo_en_nxt;
    end
  end

  assign TEST_SERIAL_OUT    = tdo_r;
  assign TEST_SERIAL_OUT_EN = tdo_en_r;
  assign BOUNDARY_PARALLEL  = bsr_par_r;
  assign ID_PARALLEL        = id_par_r;

endmodule

// ==== design/bstr_pkg.sv ====
package bstr_pkg;

  // *****************************************************
  // register sizes
  // *****************************************************
  localparam int BSTR_BYP_LEN = 1;
  localparam int BSTR_BSR_LEN = 256;
  localparam int BSTR_ID_LEN  = 32;
  localparam int BSTR_IR_LEN  = 3;

  // *****************************************************
  // instruction codes
  // *****************************************************
  localparam logic [2:0] BSTR_INS_EXTEST = 3'h0;
  localparam logic [2:0] BSTR_INS_IDCODE = 3'h1;
  localparam logic [2:0] BSTR_INS_SAMPLE = 3'h2;
  localparam logic [2:0] BSTR_INS_CLAMP  = 3'h3;
  localparam logic [2:0] BSTR_INS_HIGHZ  = 3'h4;
  localparam logic [2:0] BSTR_INS_BYPASS = 3'h7;

  // *****************************************************
  // identification code fields (values are arbitrary)
  // *****************************************************
  localparam logic [3:0]  BSTR_ID_VERSION = 4'h0;
  localparam logic [15:0] BSTR_ID_PART    = 16'h0001;
  localparam logic [10:0] BSTR_ID_MAKER   = 11'h001;
  localparam logic        BSTR_ID_LSB     = 1'b1;
  localparam int          BSTR_ID_LSB_POS   = 0;
  localparam int          BSTR_ID_MAKER_POS = 1;
  localparam int          BSTR_ID_PART_POS  = 12;
  localparam int          BSTR_ID_VER_POS   = 28;
  localparam logic [31:0] BSTR_ID_CODE =
    {BSTR_ID_VERSION, BSTR_ID_PART, BSTR_ID_MAKER, BSTR_ID_LSB};

  // *****************************************************
  // reset and capture values
  // *****************************************************
  localparam logic [BSTR_BSR_LEN-1:0] BSTR_BSR_RST = '0;
  localparam logic                    BSTR_BYP_CAPTURE = 1'b0;

  // *****************************************************
  // selected data register
  // *****************************************************
  typedef enum logic [2:0] {
    BSTR_SEL_BYP = 3'b001,
    BSTR_SEL_BSR = 3'b010,
    BSTR_SEL_ID  = 3'b100
  } bstr_sel_type;

endpackage

// ==== sim/bstr_regs_asserts.sv ====
module bstr_regs_asserts
  import bstr_pkg::*;
(
  input wire logic                    MCLK,
  input wire logic                    RESET_N,
  input wire logic                    TEST_SHIFT_CLOCK,
  input wire logic                    TAP_RESET_STATE,
  input wire logic                    TAP_SHIFT_DR,
  input wire logic                    TAP_UPDATE_DR,
  input wire logic                    TEST_SERIAL_OUT,
  input wire logic                    TEST_SERIAL_OUT_EN,
  input wire logic [BSTR_BSR_LEN-1:0] BOUNDARY_PARALLEL,
  input wire logic [BSTR_ID_LEN-1:0]  ID_PARALLEL
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  // with no test clock edge for six cycles the serial output, its enable and the boundary latch may not move
  a_out_calm: assert property ($stable(TEST_SHIFT_CLOCK)[*6] |->
    $stable(TEST_SERIAL_OUT)) else $error("serial out moved");
  a_en_calm: assert property ($stable(TEST_SHIFT_CLOCK)[*6] |->
    $stable(TEST_SERIAL_OUT_EN)) else $error("enable moved");
  a_bsr_calm: assert property ($stable(TEST_SHIFT_CLOCK)[*6] |->
    $stable(BOUNDARY_PARALLEL)) else $error("boundary latch moved");
  a_en_rise: assert property ($rose(TEST_SERIAL_OUT_EN) |->
    TAP_SHIFT_DR) else $error("enable rose outside shift");
  a_en_fall: assert property ($fell(TEST_SERIAL_OUT_EN) |->
    !TAP_SHIFT_DR) else $error("enable fell in shift");
  a_bsr_hold: assert property ((!TAP_UPDATE_DR)[*8] |->
    $stable(BOUNDARY_PARALLEL)) else $error("boundary latch without update");
  a_id_hold: assert property ((!TAP_UPDATE_DR && !TAP_RESET_STATE)[*8]
    |-> $stable(ID_PARALLEL)) else $error("id latch without update");
  a_id_reset: assert property (TAP_RESET_STATE[*4] |->
    ID_PARALLEL == BSTR_ID_CODE) else $error("id code not forced");
  c_en: cover property ($rose(TEST_SERIAL_OUT_EN));
  c_bsr: cover property (TAP_UPDATE_DR && $changed(BOUNDARY_PARALLEL));
  c_id: cover property (TAP_UPDATE_DR && $changed(ID_PARALLEL));
endmodule
bind bstr_regs bstr_regs_asserts chk (.*);

// ==== sim/bstr_tester_model.sv ====
module bstr_tester_model
(
  input  wire logic MCLK,
  input  wire logic TEST_SERIAL_OUT,
  input  wire logic TEST_SERIAL_OUT_EN,
  output logic      TEST_SHIFT_CLOCK,
  output logic      TEST_SERIAL_IN,
  output logic      TAP_RESET_STATE,
  output logic      TAP_CAPTURE_DR,
  output logic      TAP_SHIFT_DR,
  output logic      TAP_UPDATE_DR
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] st_r;
  logic       en_seen;
  assign {TAP_RESET_STATE, TAP_CAPTURE_DR, TAP_SHIFT_DR, TAP_UPDATE_DR} = st_r;
  initial {TEST_SHIFT_CLOCK, TEST_SERIAL_IN, st_r} = 6'h08;
  task automatic ticks(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  // state stands around both edges; idle data line toggles
  task automatic pulse(input logic [3:0] st, input logic din);
    st_r = st;
    TEST_SERIAL_IN = st[1] ? din : ~TEST_SERIAL_IN;
    // 20 system clocks make one 160 ns test clock period
    ticks(5);
    TEST_SHIFT_CLOCK = 1'b1;
    ticks(10);
    TEST_SHIFT_CLOCK = 1'b0;
    ticks(5);
  endtask
  // capture, n shifts lsb first, update
  task automatic scan(input int n, input logic [255:0] din,
                      output logic [255:0] dout);
    dout = '0;
    pulse(4'h4, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      dout[i] = TEST_SERIAL_OUT;
      pulse(4'h2, din[i]);
    end
    en_seen = TEST_SERIAL_OUT_EN;
    pulse(4'h1, 1'b0);
  endtask
endmodule

// ==== sim/tb.sv ====
module tb;
  import bstr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [255:0] PAT = {8{32'h3c96_e1b7}};
  logic         MCLK          = 1'b0;
  logic         RESET_N       = 1'b0;
  logic [2:0]   INSTRUCTION   = BSTR_INS_IDCODE;
  logic [255:0] BOUNDARY_PINS = {8{32'ha5c3_0f96}};
  logic [255:0] got;
  wire          TEST_SHIFT_CLOCK, TEST_SERIAL_IN, TEST_SERIAL_OUT;
  wire          TAP_RESET_STATE, TAP_CAPTURE_DR, TAP_SHIFT_DR;
  wire          TAP_UPDATE_DR, TEST_SERIAL_OUT_EN;
  wire  [255:0] BOUNDARY_PARALLEL;
  wire  [31:0]  ID_PARALLEL;
  int           bad_count   = 0;
  int           comparisons = 0;
  always #4 MCLK = ~MCLK;
  bstr_tester_model ctl (.*);
  bstr_regs dut (.*);
  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_idcode;
    chk(256'(ID_PARALLEL), 256'(BSTR_ID_CODE));
    ctl.scan(32, PAT, got);
    chk(256'(got[31:0]), 256'(BSTR_ID_CODE));
    chk(256'(ctl.en_seen), 256'(1'b1));
    chk(256'(ID_PARALLEL), 256'(PAT[31:0]));
    chk(256'(TEST_SERIAL_OUT_EN), 256'(1'b0));
  endtask
  task automatic t_bypass;
    logic [2:0] codes [5] = '{BSTR_INS_CLAMP, BSTR_INS_HIGHZ,
                              BSTR_INS_BYPASS, 3'h5, 3'h6};
    foreach (codes[k])
    begin
      INSTRUCTION = codes[k];
      ctl.scan(8, PAT, got);
      chk(256'(got[7:0]), 256'({PAT[6:0], BSTR_BYP_CAPTURE}));
      chk(256'(ID_PARALLEL), 256'(PAT[31:0]));
      chk(BOUNDARY_PARALLEL, BSTR_BSR_RST);
    end
  endtask
  task automatic t_boundary;
    logic [255:0] din;
    for (int k = 0; k < 2; k++)
    begin
      INSTRUCTION = (k == 1) ? BSTR_INS_SAMPLE : BSTR_INS_EXTEST;
      din = BOUNDARY_PINS ^ {256{k[0]}};
      ctl.scan(256, din, got);
      chk(got, BOUNDARY_PINS);
      chk(BOUNDARY_PARALLEL, din);
    end
    ctl.pulse(4'h8, 1'b0);
    chk(256'(ID_PARALLEL), 256'(BSTR_ID_CODE));
  endtask
  initial
  begin
    repeat (6) @(posedge MCLK);
    #1 RESET_N = 1'b1;
    ctl.ticks(4);
    t_idcode();
    t_bypass();
    t_boundary();
    tally_and_finish();
  end
  initial
  begin
    repeat (40000) @(posedge MCLK);
    bad_count++;
    tally_and_finish();
  end
endmodule
